// file: hw/mpo_top.sv
`timescale 1ns/10ps
// Function
// - First config bits 7:3 select the quantity for the first pulse.
// - Codes 00000, 00001, 00010: net real, absolute real, net reactive energy.
// - Code 00100 selects apparent energy, 00111 selects RMS voltage.
// - Codes 01000, 01001: real energy toward load, toward line.
// - Code 01010 selects quadrant II reactive energy.
// - First config bit 2 includes phase C in the first pulse.
// - First config bit 1 includes phase B in the first pulse.
// - First config bit 0 includes phase A in the first pulse.
// - Second config bits 7:3 select the second pulse quantity, same codes.
// - Second config bits 2,1,0 include phases C,B,A in second pulse.
// - Reset clears selection and phase bits to zero.
// - Accumulator above threshold with no pulse active fires pulse and subtracts the threshold.
// - Pulse lasts programmed frame count, default 0x9c.
module mpo_top (
   input wire logic clk,
   input wire logic nrst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [mpo_pkg::MPO_ADDR_W-1:0] reg_addr,
   input wire logic [mpo_pkg::MPO_DATA_W-1:0] reg_wdata,
   output logic [mpo_pkg::MPO_DATA_W-1:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic sample_valid,
   input wire logic frame_tick,
   input wire logic signed [mpo_pkg::MPO_VALUE_W-1:0] first_phase_a_value,
   input wire logic signed [mpo_pkg::MPO_VALUE_W-1:0] first_phase_b_value,
   input wire logic signed [mpo_pkg::MPO_VALUE_W-1:0] first_phase_c_value,
   input wire logic signed [mpo_pkg::MPO_VALUE_W-1:0] second_phase_a_value,
   input wire logic signed [mpo_pkg::MPO_VALUE_W-1:0] second_phase_b_value,
   input wire logic signed [mpo_pkg::MPO_VALUE_W-1:0] second_phase_c_value,
   output mpo_pkg::mpo_quantity_t first_quantity_source_select,
   output mpo_pkg::mpo_quantity_t second_quantity_source_select,
   output logic first_pulse_output,
   output logic second_pulse_output
);
   import mpo_pkg::*;

   logic [MPO_CFG_W-1:0] first_pulse_source_config_q, first_pulse_source_config_d;
   logic [MPO_CFG_W-1:0] second_pulse_source_config_q, second_pulse_source_config_d;
   logic [MPO_WIDTH_W-1:0] width1_q, width1_d;
   logic [MPO_WIDTH_W-1:0] width2_q, width2_d;
   logic [MPO_THR_W-1:0] thr1_q, thr1_d;
   logic [MPO_THR_W-1:0] thr2_q, thr2_d;
   logic [MPO_DATA_W-1:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;

   logic [MPO_CFG_W-1:0] cfg [MPO_CHANNELS];
   logic [MPO_THR_W-1:0] thr [MPO_CHANNELS];
   logic [MPO_WIDTH_W-1:0] wid [MPO_CHANNELS];
   logic signed [MPO_VALUE_W-1:0] phase_val [MPO_CHANNELS][MPO_PHASES];
   logic signed [MPO_ACC_W-1:0] phase_sum [MPO_CHANNELS];
   logic pulse [MPO_CHANNELS];

   // Register writes.
   always_comb begin
      first_pulse_source_config_d = first_pulse_source_config_q;
      second_pulse_source_config_d = second_pulse_source_config_q;
      width1_d = width1_q;
      width2_d = width2_q;
      thr1_d = thr1_q;
      thr2_d = thr2_q;
      if (reg_wr) begin
         case (reg_addr)
            MPO_ADDR_CFG1: first_pulse_source_config_d = reg_wdata[MPO_CFG_W-1:0];
            MPO_ADDR_CFG2: second_pulse_source_config_d = reg_wdata[MPO_CFG_W-1:0];
            MPO_ADDR_WIDTH1: width1_d = reg_wdata[MPO_WIDTH_W-1:0];
            MPO_ADDR_THR1: thr1_d = reg_wdata[MPO_THR_W-1:0];
            MPO_ADDR_WIDTH2: width2_d = reg_wdata[MPO_WIDTH_W-1:0];
            MPO_ADDR_THR2: thr2_d = reg_wdata[MPO_THR_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // Register reads; unmapped offsets return zero.
   always_comb begin
      rdata_d = rdata_q;
      rvalid_d = reg_rd;
      if (reg_rd) begin
         case (reg_addr)
            MPO_ADDR_CFG1: rdata_d = {24'h000000, first_pulse_source_config_q};
            MPO_ADDR_CFG2: rdata_d = {24'h000000, second_pulse_source_config_q};
            MPO_ADDR_WIDTH1: rdata_d = {16'h0000, width1_q};
            MPO_ADDR_THR1: rdata_d = thr1_q;
            MPO_ADDR_WIDTH2: rdata_d = {16'h0000, width2_q};
            MPO_ADDR_THR2: rdata_d = thr2_q;
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         first_pulse_source_config_q <= MPO_CFG_RST;
         second_pulse_source_config_q <= MPO_CFG_RST;
         width1_q <= MPO_WIDTH_RST;
         width2_q <= MPO_WIDTH_RST;
         thr1_q <= MPO_THR_RST;
         thr2_q <= MPO_THR_RST;
         rdata_q <= '0;
         rvalid_q <= 1'b0;
      end else begin
         first_pulse_source_config_q <= first_pulse_source_config_d;
         second_pulse_source_config_q <= second_pulse_source_config_d;
         width1_q <= width1_d;
         width2_q <= width2_d;
         thr1_q <= thr1_d;
         thr2_q <= thr2_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign reg_rvalid = rvalid_q;

   assign cfg[0] = first_pulse_source_config_q;
   assign cfg[1] = second_pulse_source_config_q;
   assign thr[0] = thr1_q;
   assign thr[1] = thr2_q;
   assign wid[0] = width1_q;
   assign wid[1] = width2_q;
   assign phase_val[0][0] = first_phase_a_value;
   assign phase_val[0][1] = first_phase_b_value;
   assign phase_val[0][2] = first_phase_c_value;
   assign phase_val[1][0] = second_phase_a_value;
   assign phase_val[1][1] = second_phase_b_value;
   assign phase_val[1][2] = second_phase_c_value;

   // The metering engine delivers the quantity named by these codes. Reserved
   // codes are passed through unchanged; what they deliver is undefined.
   // Source code decode.
   assign first_quantity_source_select =
      mpo_quantity_t'(first_pulse_source_config_q[MPO_SEL_MSB:MPO_SEL_LSB]);
   assign second_quantity_source_select =
      mpo_quantity_t'(second_pulse_source_config_q[MPO_SEL_MSB:MPO_SEL_LSB]);

   for (genvar ch = 0; ch < MPO_CHANNELS; ch++) begin : g_chan
      always_comb begin
         phase_sum[ch] =
            (cfg[ch][MPO_PH_A_BIT] ? MPO_ACC_W'(phase_val[ch][0]) : '0) +
            (cfg[ch][MPO_PH_B_BIT] ? MPO_ACC_W'(phase_val[ch][1]) : '0) +
            (cfg[ch][MPO_PH_C_BIT] ? MPO_ACC_W'(phase_val[ch][2]) : '0);
      end

      mpo_pulse_channel u_chan (
         .clk(clk),
         .nrst(nrst),
         .sample_valid(sample_valid),
         .sample_sum(phase_sum[ch]),
         .frame_tick(frame_tick),
         .threshold(thr[ch]),
         .width(wid[ch]),
         .pulse_out(pulse[ch])
      );
   end

   assign first_pulse_output = pulse[0];
   assign second_pulse_output = pulse[1];

endmodule // mpo_top

// file: include/mpo_pkg.sv
package mpo_pkg;

   // Register indices; the printed offsets are used as-is on the register port.
   localparam logic [8:0] MPO_ADDR_CFG1 = 9'h01e;
   localparam logic [8:0] MPO_ADDR_CFG2 = 9'h01f;
   localparam logic [8:0] MPO_ADDR_WIDTH1 = 9'h020;
   localparam logic [8:0] MPO_ADDR_THR1 = 9'h022;
   localparam logic [8:0] MPO_ADDR_WIDTH2 = 9'h026;
   localparam logic [8:0] MPO_ADDR_THR2 = 9'h028;

   localparam int MPO_ADDR_W = 9;
   localparam int MPO_DATA_W = 32;
   localparam int MPO_CFG_W = 8;
   localparam int MPO_WIDTH_W = 16;
   localparam int MPO_THR_W = 32;
   localparam int MPO_VALUE_W = 32;
   localparam int MPO_ACC_W = 48;
   localparam int MPO_CHANNELS = 2;
   localparam int MPO_PHASES = 3;

   // Configuration field layout.
   localparam int MPO_SEL_MSB = 7;
   localparam int MPO_SEL_LSB = 3;
   localparam int MPO_PH_C_BIT = 2;
   localparam int MPO_PH_B_BIT = 1;
   localparam int MPO_PH_A_BIT = 0;

   // Reset values.
   localparam logic [7:0] MPO_CFG_RST = 8'h00;
   localparam logic [15:0] MPO_WIDTH_RST = 16'h009c;
   localparam logic [31:0] MPO_THR_RST = 32'h0010_0000;

   typedef enum logic [4:0] {
      MPO_Q_NET_REAL = 5'h00,
      MPO_Q_ABS_REAL = 5'h01,
      MPO_Q_NET_REACTIVE = 5'h02,
      MPO_Q_APPARENT = 5'h04,
      MPO_Q_VRMS = 5'h07,
      MPO_Q_REAL_TO_LOAD = 5'h08,
      MPO_Q_REAL_TO_LINE = 5'h09,
      MPO_Q_REACTIVE_Q2 = 5'h0a
   } mpo_quantity_t;

   typedef enum logic [1:0] {
      MPO_ST_IDLE = 2'b01,
      MPO_ST_ACTIVE = 2'b10
   } mpo_state_t;

endpackage

// file: hw/mpo_pulse_channel.sv
`timescale 1ns/10ps
module mpo_pulse_channel (
   input wire logic clk,
   input wire logic nrst,
   input wire logic sample_valid,
   input wire logic signed [mpo_pkg::MPO_ACC_W-1:0] sample_sum,
   input wire logic frame_tick,
   input wire logic [mpo_pkg::MPO_THR_W-1:0] threshold,
   input wire logic [mpo_pkg::MPO_WIDTH_W-1:0] width,
   output logic pulse_out
);
   import mpo_pkg::*;

   mpo_state_t state_q, state_d;
   logic signed [MPO_ACC_W-1:0] acc_q, acc_d;
   logic [MPO_WIDTH_W-1:0] count_q, count_d;
   logic signed [MPO_ACC_W-1:0] thr_ext;
   logic fire;
   logic pulse_d;

   assign thr_ext = {{(MPO_ACC_W-MPO_THR_W){1'b0}}, threshold};

   always_comb begin
      state_d = state_q;
      count_d = count_q;
      fire = (state_q == MPO_ST_IDLE) && (acc_q > thr_ext);
      acc_d = acc_q + (sample_valid ? sample_sum : '0);
      if (fire) begin
         acc_d = acc_d - thr_ext;
      end
      case (state_q)
         MPO_ST_IDLE: begin
            if (fire) begin
               state_d = MPO_ST_ACTIVE;
               count_d = width;
            end
         end
         MPO_ST_ACTIVE: begin
            if (count_q == '0) begin
               state_d = MPO_ST_IDLE;
            end else if (frame_tick) begin
               count_d = count_q - 1'b1;
               if (count_q == 16'h0001) begin
                  state_d = MPO_ST_IDLE;
               end
            end
         end
         default: begin
            state_d = MPO_ST_IDLE;
            count_d = '0;
         end
      endcase
      pulse_d = (state_d == MPO_ST_ACTIVE);
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_q <= MPO_ST_IDLE;
         acc_q <= '0;
         count_q <= '0;
         pulse_out <= 1'b0;
      end else begin
         state_q <= state_d;
         acc_q <= acc_d;
         count_q <= count_d;
         pulse_out <= pulse_d;
      end
   end

endmodule // mpo_pulse_channel

// file: verif/mpo_host_model.sv
`timescale 1ns/10ps
module mpo_host_model (
   input wire logic clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [mpo_pkg::MPO_ADDR_W-1:0] reg_addr,
   output logic [mpo_pkg::MPO_DATA_W-1:0] reg_wdata
);
   import mpo_pkg::*;
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
   end
   // One strobe cycle per access; the next access waits for a fresh edge.
   task automatic xfer(input logic w, input logic [8:0] a, input logic [31:0] d);
      @(posedge clk);
      #1;
      reg_wr = w;
      reg_rd = !w;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      // Released lines show the inverse, never the last value.
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
endmodule // mpo_host_model

// file: verif/mpo_top_monitor.sv
`timescale 1ns/10ps
module mpo_top_monitor (
   input wire logic clk,
   input wire logic nrst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [mpo_pkg::MPO_ADDR_W-1:0] reg_addr,
   input wire logic [mpo_pkg::MPO_DATA_W-1:0] reg_wdata,
   input wire logic [mpo_pkg::MPO_DATA_W-1:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic frame_tick,
   input wire logic [4:0] first_quantity_source_select,
   input wire logic [4:0] second_quantity_source_select,
   input wire logic first_pulse_output,
   input wire logic second_pulse_output
);
   import mpo_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_wr1;
      reg_wr && reg_addr == MPO_ADDR_CFG1;
   endsequence
   sequence s_wr2;
      reg_wr && reg_addr == MPO_ADDR_CFG2;
   endsequence
   sequence s_rd1;
      reg_rd && !reg_wr && reg_addr == MPO_ADDR_CFG1;
   endsequence
   property p_rvalid; reg_rd |=> reg_rvalid; endproperty
   property p_rst; $rose(nrst) |-> first_quantity_source_select == MPO_Q_NET_REAL &&
      second_quantity_source_select == MPO_Q_NET_REAL && !first_pulse_output &&
      !second_pulse_output && !reg_rvalid;
   endproperty
   property p_sel1; s_wr1 |=> first_quantity_source_select == $past(reg_wdata[7:3]); endproperty
   property p_sel2; s_wr2 |=> second_quantity_source_select == $past(reg_wdata[7:3]); endproperty
   property p_hold; !(reg_wr && reg_addr[8:1] == 8'h0f) |=>
      $stable(first_quantity_source_select) && $stable(second_quantity_source_select);
   endproperty
   property p_rd1; s_rd1 |=> reg_rdata[7:3] == $past(first_quantity_source_select); endproperty
   property p_unmap; reg_rd && !reg_wr && reg_addr == 9'h000 |=> reg_rdata == '0; endproperty
   // A pulse past its first cycle may only end at an edge that takes a frame tick.
   property p_wid1; first_pulse_output && $past(first_pulse_output) && !frame_tick |=>
      first_pulse_output; endproperty
   property p_wid2; second_pulse_output && $past(second_pulse_output) && !frame_tick |=>
      second_pulse_output; endproperty
   a_rvalid: assert property (p_rvalid) else $error("read without valid");
   a_rst: assert property (p_rst) else $error("reset values wrong");
   a_sel1: assert property (p_sel1) else $error("first select not written");
   a_sel2: assert property (p_sel2) else $error("second select not written");
   a_hold: assert property (p_hold) else $error("select changed unasked");
   a_rd1: assert property (p_rd1) else $error("first config readback wrong");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_wid1: assert property (p_wid1) else $error("first pulse ended without a frame");
   a_wid2: assert property (p_wid2) else $error("second pulse ended without a frame");
endmodule // mpo_top_monitor
bind mpo_top mpo_top_monitor mpo_top_monitor_i (.clk, .nrst, .reg_wr, .reg_rd, .reg_addr,
   .reg_wdata, .reg_rdata, .reg_rvalid, .frame_tick, .first_quantity_source_select,
   .second_quantity_source_select, .first_pulse_output, .second_pulse_output);

// file: verif/test_mpo_top.sv
`timescale 1ns/10ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module test_mpo_top;
   import mpo_pkg::*;
   logic clk, nrst, sample_valid, frame_tick, reg_wr, reg_rd, reg_rvalid, fp, sp, pp1, pp2;
   logic [8:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rv;
   logic [7:0] w;
   logic [1:0] pv, pe;
   logic signed [31:0] v [6];
   mpo_quantity_t q1, q2;
   logic [31:0] rq [$];
   logic [1:0] pq [$];
   int errors = 0;
   int tests_run = 0;
   logic [4:0] codes [8] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h07, 5'h08, 5'h09, 5'h0a};
   mpo_host_model mpo_host_model_i (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
   mpo_top mpo_top_i (.clk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .reg_rvalid, .sample_valid, .frame_tick, .first_phase_a_value(v[0]),
      .first_phase_b_value(v[1]), .first_phase_c_value(v[2]), .second_phase_a_value(v[3]),
      .second_phase_b_value(v[4]), .second_phase_c_value(v[5]),
      .first_quantity_source_select(q1), .second_quantity_source_select(q2),
      .first_pulse_output(fp), .second_pulse_output(sp));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic results();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      results();
   end
   task automatic wr(input logic [8:0] a, input logic [31:0] d);
      mpo_host_model_i.xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [8:0] a, input logic [31:0] e);
      rq.push_back(e);
      mpo_host_model_i.xfer(1'b0, a, 32'h0);
   endtask
   task automatic rst();
      nrst = 1'b0;
      repeat (4) @(posedge clk);
      #1 nrst = 1'b1;
   endtask
   task automatic tick();
      @(posedge clk);
      #1 frame_tick = 1'b1;
      @(posedge clk);
      #1 frame_tick = 1'b0;
   endtask
   // Phases in mask m carry x, the others y; e lists the outputs that must fire.
   task automatic smp(input logic [2:0] m, input logic signed [31:0] x, y, input logic [1:0] e);
      @(posedge clk);
      #1;
      for (int k = 0; k < 6; k++) v[k] = m[k % 3] ? x : y;
      sample_valid = 1'b1;
      if (e != 2'b00) pq.push_back(e);
      @(posedge clk);
      #1 sample_valid = 1'b0;
      repeat (3) @(posedge clk);
   endtask
   // Results are matched against the oldest note as they appear.
   always @(posedge clk) begin
      if (reg_rvalid === 1'b1) begin
         rv = rq.size() ? rq.pop_front() : 32'hx;
         `CHK(reg_rdata, rv)
      end
      pv = {fp, sp};
      if ((fp & !pp1) | (sp & !pp2)) begin
         pe = pq.size() ? pq.pop_front() : 2'bxx;
         `CHK(pv, pe)
      end
      pp1 <= fp;
      pp2 <= sp;
   end
   initial begin
      sample_valid = 1'b0;
      frame_tick = 1'b0;
      v = '{6{32'sh0}};
      void'($urandom(32'h87dc));
      rst();
      rd(MPO_ADDR_CFG2, 32'h0);
      rd(MPO_ADDR_WIDTH1, 32'h9c);
      rd(MPO_ADDR_THR2, 32'h0010_0000);
      rd(9'h000, 32'h0);
      `CHK(q1, MPO_Q_NET_REAL)
      foreach (codes[i]) begin
         w = {codes[i], 3'($urandom)};
         wr(MPO_ADDR_CFG1, {24'h0, w});
         wr(MPO_ADDR_CFG2, {24'h0, codes[7 - i], ~w[2:0]});
         rd(MPO_ADDR_CFG1, {24'h0, w});
         rd(MPO_ADDR_CFG2, {24'h0, codes[7 - i], ~w[2:0]});
         `CHK(q1, codes[i])
         `CHK(q2, codes[7 - i])
      end
      wr(MPO_ADDR_THR1, 32'ha);
      wr(MPO_ADDR_THR2, 32'ha);
      wr(MPO_ADDR_WIDTH1, 32'h1);
      wr(MPO_ADDR_WIDTH2, 32'h1);
      for (int p = 0; p < 3; p++) begin
         wr(MPO_ADDR_CFG1, {24'h0, codes[p], 3'(1 << p)});
         wr(MPO_ADDR_CFG2, {24'h0, codes[p], 3'(1 << p)});
         smp(3'(1 << p), 32'sh0, 32'shb, 2'b00);
         smp(3'(1 << p), 32'shb, -32'shb, 2'b11);
         tick();
      end
      rst();
      wr(MPO_ADDR_THR1, 32'ha);
      wr(MPO_ADDR_CFG1, 32'h1);
      wr(MPO_ADDR_WIDTH1, 32'h2);
      smp(3'b001, 32'sha, 32'sh5, 2'b00);
      smp(3'b001, 32'sh1, 32'sh5, 2'b10);
      tick();
      `CHK(fp, 1'b1)
      tick();
      `CHK(fp, 1'b0)
      smp(3'b001, 32'sh9, 32'sh5, 2'b00);
      smp(3'b001, 32'sh1, 32'sh5, 2'b10);
      repeat (3) @(posedge clk);
      `CHK(pq.size() + rq.size(), 0)
      results();
   end
endmodule // test_mpo_top
